// *** pwm_pkg.sv ***
// Purpose: shared constants for the sub-cycle pwm generator
// Assumes: 32-bit axi4-lite register access, 100 MHz clk_sys
// Notes: register map below is fixed for software
package pwm_pkg;
	// ****************
	// bus geometry
	// ****************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DUTY_W = 8;
	localparam int PORT_W = 4;
	// ****************
	// register offsets
	// ****************
	localparam logic [ADDR_W-1:0] OFF_DUTY0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DUTY1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DUTY2 = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_DUTY3 = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_DIR = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_PIN_IN = 8'h20;
	// ****************
	// fields and reset values
	// ****************
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_EN_LSB = 4;
	localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;
	localparam logic [PORT_W-1:0] DIR_RST = 4'hf;
	localparam logic [PORT_W-1:0] LATCH_RST = 4'h0;
	localparam logic [PORT_W-1:0] EN_RST = 4'h0;
	localparam logic MODE_RST = 1'b0;
	// ****************
	// cycle geometry, response codes and sub-mode type
	// ****************
	localparam int FULL_CYCLE = 256;
	localparam int SUB_FOUR = 64;
	localparam int SUB_TWO = 128;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic {MODE_FOUR, MODE_TWO} submode_t;
endpackage

// *** pwm_channel.sv ***
// Purpose: one pwm channel waveform from shared cycle counter
// Assumes: cycle counter wraps every 256 clocks
// Notes: duty is latched as the counter wraps from 255 to zero
module pwm_channel
	import pwm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// timing
	input wire logic [7:0] cycleCnt,
	input wire logic modeTwo,
	// duty
	input wire logic [pwm_pkg::DUTY_W-1:0] dutyReg,
	// waveform
	output logic wave
);
	import pwm_pkg::*;

	logic [DUTY_W-1:0] dutyAct_ff;
	logic [6:0] coarseDuty;
	logic [1:0] fineCount;
	logic [6:0] subPos;
	logic [1:0] subIdx;
	logic [7:0] highLen;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dutyAct_ff <= DUTY_RST;
		end else if (cycleCnt == 8'hff) begin
			dutyAct_ff <= dutyReg;
		end
	end

	always_comb begin
		if (modeTwo) begin
			coarseDuty = dutyAct_ff[7:1];
			fineCount = {1'b0, dutyAct_ff[0]};
			subPos = cycleCnt[6:0];
			subIdx = {1'b0, cycleCnt[7]};
		end else begin
			coarseDuty = {1'b0, dutyAct_ff[7:2]};
			fineCount = dutyAct_ff[1:0];
			subPos = {1'b0, cycleCnt[5:0]};
			subIdx = cycleCnt[7:6];
		end
		// extra clock when i below fine
		highLen = {1'b0, coarseDuty} + ((subIdx < fineCount) ? 8'h01 : 8'h00);
	end

	assign wave = ({1'b0, subPos} < highLen);
endmodule

// *** subcycle_pwm_generator.sv ***
// Function
// - full cycle is 256 clocks, duty equals value over 256
// - modulation period 128 clocks in two-sub mode, 64 in four-sub mode
// - counter runs straight off the system clock, no prescaler
// - each channel has a software-written 8-bit duty register
// - four-sub mode splits the cycle into four 64-clock parts
// - four-sub mode: bits 7..2 coarse, bits 1..0 fine
// - four-sub part i high coarse+1 clocks if i below fine, else coarse
// - two-sub mode splits the cycle into two 128-clock parts
// - two-sub mode: bits 7..1 coarse, bit 0 fine
// - two-sub part i high coarse+1 clocks if i below fine, else coarse
// - option on, output direction, latch one: pin carries waveform
// - latch zero holds the pin low
// - direction one leaves the pin a plain input
// - one mode setting serves every channel
// - three or four channels on port bits 0 to 3
//
// Purpose: multi-channel sub-cycle pwm with axi4-lite registers
// Assumes: single 100 MHz clock, asynchronous active-low reset
// Notes: pins are split into in, out and output enable
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
module subcycle_pwm_generator
	import pwm_pkg::*;
#(
	parameter int NUM_CH = 4
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// axi write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pwm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// axi write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [pwm_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [pwm_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// axi read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [pwm_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// port pins
	input wire logic [pwm_pkg::PORT_W-1:0] pinIn,
	output logic [pwm_pkg::PORT_W-1:0] pinOut,
	output logic [pwm_pkg::PORT_W-1:0] pinOe
);
	import pwm_pkg::*;

	// ****************
	// registers
	// ****************
	logic [DUTY_W-1:0] dutyValue_ff [PORT_W];
	logic [PORT_W-1:0] portDirectionReg_ff;
	logic [PORT_W-1:0] portOutputLatch_ff;
	logic [PORT_W-1:0] pwmEnable_ff;
	logic subMode_ff;
	logic [7:0] cycleCnt_ff;
	logic [PORT_W-1:0] pinMeta_ff;
	logic [PORT_W-1:0] pinSync_ff;
	logic [PORT_W-1:0] pinOut_ff;
	logic [PORT_W-1:0] pinOe_ff;
	logic [PORT_W-1:0] wave;

	// axi state
	logic awHeld_ff;
	logic wHeld_ff;
	logic [ADDR_W-1:0] awAddr_ff;
	logic [DATA_W-1:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic bValid_ff;
	logic [1:0] bResp_ff;
	logic rValid_ff;
	logic [DATA_W-1:0] rData_ff;
	logic [1:0] rResp_ff;
	logic doWrite;
	logic wrHit;
	logic [DATA_W-1:0] nxt_rData;
	logic rdHit;
	logic awReady_ff;
	logic wReady_ff;
	logic arReady_ff;
	logic nxt_awHeld;
	logic nxt_wHeld;
	logic nxt_bValid;
	logic nxt_rValid;

	// register index check, used by read and write
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic ok;
		ok = 1'b0;
		case (a)
			OFF_DUTY0, OFF_DUTY1, OFF_DUTY2: ok = 1'b1;
			OFF_DUTY3: ok = (NUM_CH > 3);
			OFF_DIR, OFF_LATCH, OFF_CTRL, OFF_STATUS, OFF_PIN_IN: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// ****************
	// axi write path
	// ****************
	assign s_axi_awready = awReady_ff;
	assign s_axi_wready = wReady_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	assign wrHit = isMapped(awAddr_ff);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wHeld_ff <= 1'b0;
			wData_ff <= '0;
			wStrb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bValid_ff <= 1'b0;
			bResp_ff <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_ff <= 1'b1;
			bResp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < PORT_W; c++) begin
				dutyValue_ff[c] <= DUTY_RST;
			end
		end else if (doWrite && wStrb_ff[0]) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (awAddr_ff == 8'(OFF_DUTY0 + 4 * c)) begin
					dutyValue_ff[c] <= wData_ff[DUTY_W-1:0];
				end
			end
		end
	end

	// port control, mode and option enables
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			portDirectionReg_ff <= DIR_RST;
			portOutputLatch_ff <= LATCH_RST;
			pwmEnable_ff <= EN_RST;
			subMode_ff <= MODE_RST;
		end else if (doWrite && wStrb_ff[0]) begin
			case (awAddr_ff)
				OFF_DIR: portDirectionReg_ff <= wData_ff[PORT_W-1:0];
				OFF_LATCH: portOutputLatch_ff <= wData_ff[PORT_W-1:0];
				OFF_CTRL: begin
					subMode_ff <= wData_ff[CTRL_MODE_BIT];
					pwmEnable_ff <= wData_ff[CTRL_EN_LSB +: PORT_W];
				end
				default: ;
			endcase
		end
	end

	// ****************
	// axi read path
	// ****************
	assign s_axi_arready = arReady_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;
	assign rdHit = isMapped(s_axi_araddr);

	always_comb begin
		nxt_rData = '0;
		case (s_axi_araddr)
			OFF_DUTY0: nxt_rData = {24'h0, dutyValue_ff[0]};
			OFF_DUTY1: nxt_rData = {24'h0, dutyValue_ff[1]};
			OFF_DUTY2: nxt_rData = {24'h0, dutyValue_ff[2]};
			OFF_DUTY3: nxt_rData = (NUM_CH > 3) ? {24'h0, dutyValue_ff[3]} : '0;
			OFF_DIR: nxt_rData = {28'h0, portDirectionReg_ff};
			OFF_LATCH: nxt_rData = {28'h0, portOutputLatch_ff};
			OFF_CTRL: nxt_rData = {24'h0, pwmEnable_ff, 3'h0, subMode_ff};
			// live counter and drive state
			OFF_STATUS: nxt_rData = {16'h0, cycleCnt_ff, pinOe_ff, pinOut_ff};
			OFF_PIN_IN: nxt_rData = {28'h0, pinSync_ff};
			default: nxt_rData = '0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rValid_ff <= 1'b0;
			rData_ff <= '0;
			rResp_ff <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rValid_ff <= 1'b1;
			rData_ff <= nxt_rData;
			rResp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_ff <= 1'b0;
		end
	end

	// ****************
	// ready flags
	// ****************
	// next holding state, so readies can come from flops
	always_comb begin
		nxt_awHeld = awHeld_ff;
		nxt_wHeld = wHeld_ff;
		nxt_bValid = bValid_ff;
		nxt_rValid = rValid_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_awHeld = 1'b1;
		end else if (doWrite) begin
			nxt_awHeld = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_wHeld = 1'b1;
		end else if (doWrite) begin
			nxt_wHeld = 1'b0;
		end
		if (doWrite) begin
			nxt_bValid = 1'b1;
		end else if (s_axi_bready) begin
			nxt_bValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rValid = 1'b1;
		end else if (s_axi_rready) begin
			nxt_rValid = 1'b0;
		end
	end

	// readies drop with the take, never a cycle late
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			awReady_ff <= 1'b1;
			wReady_ff <= 1'b1;
			arReady_ff <= 1'b1;
		end else begin
			awReady_ff <= !nxt_awHeld && !nxt_bValid;
			wReady_ff <= !nxt_wHeld && !nxt_bValid;
			arReady_ff <= !nxt_rValid;
		end
	end

	// ****************
	// cycle counter
	// ****************
	// free 256-clock count on clk_sys
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cycleCnt_ff <= 8'h00;
		end else begin
			cycleCnt_ff <= cycleCnt_ff + 8'h01;
		end
	end

	// ****************
	// channels
	// ****************
	// per-channel waveform, shared mode
	for (genvar c = 0; c < PORT_W; c++) begin : gCh
		if (c < NUM_CH) begin : gOn
			pwm_channel uChan (
				.clk_sys(clk_sys),
				.rstn(rstn),
				.cycleCnt(cycleCnt_ff),
				.modeTwo(subMode_ff == MODE_TWO),
				.dutyReg(dutyValue_ff[c]),
				.wave(wave[c])
			);
		end else begin : gOff
			assign wave[c] = 1'b0;
		end
	end

	// ****************
	// pin control
	// ****************
	// input sampled twice before software sees it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pinMeta_ff <= '0;
			pinSync_ff <= '0;
		end else begin
			pinMeta_ff <= pinIn;
			pinSync_ff <= pinMeta_ff;
		end
	end

	// registered so pins never glitch on decode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pinOut_ff <= '0;
			pinOe_ff <= '0;
		end else begin
			for (int c = 0; c < PORT_W; c++) begin
				pinOe_ff[c] <= !portDirectionReg_ff[c];
				if (pwmEnable_ff[c]) begin
					pinOut_ff[c] <= portOutputLatch_ff[c] && wave[c];
				end else begin
					pinOut_ff[c] <= portOutputLatch_ff[c];
				end
			end
		end
	end

	assign pinOut = pinOut_ff;
	assign pinOe = pinOe_ff;
endmodule

// *** subcycle_pwm_generator_assertions.sv ***
// Purpose: bus and pin checks beside the pwm generator
// Assumes: one clock, asynchronous active-low reset
// Notes: duty shapes are judged by the bench, not here
module subcycle_pwm_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [3:0] pinOe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (rdTaken |=> s_axi_rvalid)
		else $error("read not answered");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	// enables move only as a register write lands
	chk_oe_follow: assert property ($changed(pinOe) |-> s_axi_bvalid
		|| $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("enable moved alone");
endmodule
bind subcycle_pwm_generator subcycle_pwm_checker u_checker (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.pinOe(pinOe)
);

// *** pwm_load.sv ***
// Purpose: averaging load on the four pwm pins
// Assumes: released pins float up to a pull-high
// Notes: counts high clocks and rising edges per pin
module pwm_load (
	input wire logic clk_sys,
	input wire logic clear,
	input wire logic [3:0] pinOut,
	input wire logic [3:0] pinOe,
	output logic [3:0] pinIn,
	output logic [3:0][8:0] highCnt,
	output logic [3:0][8:0] riseCnt
);
	logic [3:0] prevPin;
	// undriven pin reads high, never a stale level
	assign pinIn = (pinOut & pinOe) | ~pinOe;
	always_ff @(posedge clk_sys) begin
		prevPin <= pinIn;
		for (int c = 0; c < 4; c++) begin
			if (clear) begin
				highCnt[c] <= '0;
				riseCnt[c] <= '0;
			end else begin
				highCnt[c] <= highCnt[c] + 9'(pinIn[c]);
				riseCnt[c] <= riseCnt[c] + 9'(pinIn[c] & ~prevPin[c]);
			end
		end
	end
endmodule

// *** subcycle_pwm_generator_tb.sv ***
// Purpose: self-checking bench for the pwm generator
// Assumes: default of four channels
// Notes: measure windows span 256 clocks, so alignment does not matter there; test_sync aligns a 200-clock window to pin 0
module subcycle_pwm_generator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pwm_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, clear = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [PORT_W-1:0] pinIn, pinOut, pinOe;
	logic [3:0][8:0] highCnt, riseCnt;
	int fail_count = 0, checked = 0;
	subcycle_pwm_generator u_dut (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.pinIn(pinIn),
		.pinOut(pinOut),
		.pinOe(pinOe)
	);
	pwm_load u_load (
		.clk_sys(clk_sys),
		.clear(clear),
		.pinOut(pinOut),
		.pinOe(pinOe),
		.pinIn(pinIn),
		.highCnt(highCnt),
		.riseCnt(riseCnt)
	);
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// lag holds the answer ready low for that many edges
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input int lag = 0);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (lag > 0) lag--;
			if (lag == 0) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axiRead(input logic [7:0] a, input int lag = 0);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (lag > 0) lag--;
			if (lag == 0) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// settle past a cycle boundary, then count one full cycle
	task automatic measure;
		repeat (600) @(posedge clk_sys);
		clear <= 1'b1;
		@(posedge clk_sys);
		clear <= 1'b0;
		repeat (256) @(posedge clk_sys);
		#1;
	endtask
	task automatic test_regs;
		axiRead(OFF_DIR, 3);
		check(rd, 32'h0000000f);
		check(pinIn, 4'hf);
		axiWrite(8'h40, 32'h00000055, 3);
		check(rsp, RESP_SLVERR);
		axiRead(8'h40);
		check(rsp, RESP_SLVERR);
		$display("test_regs done");
	endtask
	task automatic test_duty(input logic md, input logic [3:0][7:0] dv, input logic [3:0][8:0] rs);
		axiWrite(OFF_DIR, 32'h0);
		axiWrite(OFF_LATCH, 32'hf);
		axiWrite(OFF_CTRL, {24'h0, 4'hf, 3'h0, md});
		for (int c = 0; c < 4; c++) axiWrite(OFF_DUTY0 + 8'(4 * c), {24'h0, dv[c]});
		measure();
		for (int c = 0; c < 4; c++) begin
			check(highCnt[c], dv[c]);
			check(riseCnt[c], rs[c]);
		end
		$display("test_duty done");
	endtask
	task automatic test_gate;
		axiWrite(OFF_LATCH, 32'h5);
		axiWrite(OFF_DIR, 32'h4);
		measure();
		check(highCnt[1], 9'd0);
		check(highCnt[3], 9'd0);
		check(highCnt[2], 9'd256);
		check(pinOe, 4'hb);
		check(highCnt[0], 9'h64);
		axiRead(OFF_PIN_IN);
		check(rd[2], 1'b1);
		$display("test_gate done");
	endtask
	task automatic test_sync;
		axiWrite(OFF_DIR, 32'h0);
		axiWrite(OFF_LATCH, 32'hf);
		axiWrite(OFF_CTRL, {24'h0, 4'hf, 3'h0, 1'b0});
		axiWrite(OFF_DUTY0, 32'h00000001);
		axiWrite(OFF_DUTY1, 32'h00000000);
		axiRead(OFF_DUTY0);
		check(rd, 32'h00000001);
		repeat (300) @(posedge clk_sys);
		// single high clock on pin 0 marks the cycle start
		do @(posedge clk_sys); while (pinIn[0] !== 1'b1);
		axiWrite(OFF_DUTY1, 32'h000000ff);
		clear <= 1'b1;
		@(posedge clk_sys);
		clear <= 1'b0;
		repeat (200) @(posedge clk_sys);
		#1;
		check(highCnt[1], 9'd0);
		measure();
		check(highCnt[1], 9'hff);
		check(riseCnt[0], 9'd1);
		// option off: pin shows the latch level
		axiWrite(OFF_CTRL, 32'h0);
		measure();
		check(highCnt[0], 9'd256);
		$display("test_sync done");
	endtask
	initial begin
		#300000;
		fail_count++;
		results();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		test_regs();
		// one extra high clock per early part shows up as extra pulses
		test_duty(1'b0, {8'h01, 8'hff, 8'h03, 8'h64}, {9'd1, 9'd1, 9'd3, 9'd4});
		test_duty(1'b1, {8'h01, 8'hff, 8'h03, 8'h64}, {9'd1, 9'd1, 9'd2, 9'd2});
		test_gate();
		test_sync();
		results();
	end
endmodule
